//--- logic/eeprom_target.sv
// Two-wire serial EEPROM target: bus front end, write guard, page program cycle
// Function
// [RQ1] Sample data at SCL rise, change driven data at SCL fall.
// [RQ2] Controller keeps SCL at or below the maximum serial rate.
// [RQ3] Controller changes SDA only while SCL low, except start and stop.
// [RQ4] Device only pulls SDA low or releases it, never drives high.
// [RQ5] Device answers only when received 3-bit address equals strap pins.
// [RQ6] Guard input high blocks programming of the upper eighth of the array.
// [RQ7] Guard input low lets writes reach every location.
// [RQ8] Reads work over the whole array whatever the guard input level.
// [RQ9] System holds the guard input steady for each operation.
// [RQ10] Program cycle ends within the program time after the stop.
// [RQ11] Array holds 16384 or 32768 bytes with 14 or 15 address bits.
// [RQ12] Up to one 64-byte page buffered, programmed in one cycle.
// [RQ13] SDA fall with SCL high starts; SDA rise with SCL high stops.
// [RQ14] First byte: type code, three strap bits, then direction bit.
// [RQ15] Ninth clock carries acknowledge low from the receiver.
// [RQ16] During programming, bus ignored and address not acknowledged.
// [RQ17] Guarded writes leave the array unchanged; they are still acknowledged.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_target_map.svh"
module eeprom_target #(
    parameter int ADDR_BITS = 15,
    parameter longint PROG_TIME_MS = `PROG_TIME_FAST_MS,
    parameter longint PROG_CYCLES = (PROG_TIME_MS * `PS_PER_MS) / `CLK_PERIOD_PS
) (
    input wire logic clk,
    input wire logic rst,
    input wire eeprom_target_pkg::bus_pins_t bus_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] bus_select_straps,
    input wire logic write_guard,
    output logic programming
);
    import eeprom_target_pkg::*;

    localparam int DEPTH = 1 << ADDR_BITS;
    localparam int PW = $bits(page_word_t);
    initial
    begin
        if (ADDR_BITS != 14 && ADDR_BITS != 15)
            $error("ADDR_BITS must be 14 or 15");
        if (PROG_CYCLES < 1 || PROG_CYCLES > 64'hffffffff)
            $error("PROG_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------
    logic scl_q, sda_q;
    wire scl_rise = bus_in.scl && !scl_q;
    wire scl_fall = !bus_in.scl && scl_q;
    wire start_cond = scl_q && bus_in.scl && sda_q && !bus_in.sda; // [RQ13]
    wire stop_cond = scl_q && bus_in.scl && !sda_q && bus_in.sda; // [RQ13]

    bus_state_t state_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [ADDR_BITS-1:0] addr_q;
    logic [7:0] hi_q;
    logic ack_phase_q, ack_drive_q, tx_bit_q, page_dirty_q, nack_seen_q;
    logic [31:0] prog_cnt_q;
    logic [7:0] mem [DEPTH];
    logic [7:0] page_data [`PAGE_BYTES];
    logic [`PAGE_BYTES-1:0] page_valid_q;
    logic [ADDR_BITS-`PAGE_ADDR_BITS-1:0] page_base_q;

    wire byte_done = scl_rise && !ack_phase_q && (bit_q == `BIT_COUNT_LAST - 4'h1);
    wire [7:0] rx_byte = {shift_q[6:0], bus_in.sda};
    wire addr_match = (rx_byte[7:4] == `DEV_TYPE_CODE) && (rx_byte[3:1] == bus_select_straps); // [RQ5] [RQ14]
    wire ack_end = scl_fall && ack_phase_q;
    wire guarded = write_guard && (addr_q[ADDR_BITS-1 -: 3] == 3'b111); // [RQ6] [RQ7] [RQ9]
    wire prog_done = (state_q == ST_PROGRAM) && (prog_cnt_q == 32'(PROG_CYCLES - 1)); // [RQ10]

    // ------------------------------------------------------------
    // Received bytes pass through the FIFO into the page buffer
    // ------------------------------------------------------------
    page_word_t fifo_in, fifo_out;
    logic fifo_in_ready, fifo_out_valid;
    wire wdata_push = byte_done && (state_q == ST_WDATA) && !guarded; // [RQ17]
    assign fifo_in = '{offset: addr_q[`PAGE_ADDR_BITS-1:0], data: rx_byte};
    page_fifo #(.WIDTH(PW), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(1'b0),
        .in_data(fifo_in),
        .in_valid(wdata_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1)
    );
    // Page buffer drains one entry per cycle, far faster than a bus byte
    always_ff @(posedge clk)
    begin
        if (fifo_out_valid)
            page_data[fifo_out.offset] <= fifo_out.data; // [RQ12]
    end

    // ------------------------------------------------------------
    // Array: programmed from the page buffer in one cycle
    // ------------------------------------------------------------
    // One process writes the buffered bytes of the page so the array has a single driver
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < `PAGE_BYTES; i++)
        begin
            if (prog_done && page_valid_q[i])
                mem[{page_base_q, 6'(i)}] <= page_data[i]; // [RQ11] [RQ12]
        end
    end

    // ------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            addr_q <= '0;
            hi_q <= 8'h00;
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
            tx_bit_q <= 1'b1;
            page_dirty_q <= 1'b0;
            page_valid_q <= '0;
            page_base_q <= '0;
            nack_seen_q <= 1'b0;
            prog_cnt_q <= 32'h0;
        end
        else
        begin
            scl_q <= bus_in.scl;
            sda_q <= bus_in.sda;
            if (state_q == ST_PROGRAM)
            begin
                // Bus ignored, address never acknowledged while programming
                ack_drive_q <= 1'b0; // [RQ16]
                tx_bit_q <= 1'b1;
                prog_cnt_q <= prog_cnt_q + 32'h1;
                if (prog_done)
                begin
                    state_q <= ST_IDLE; // [RQ10] [RQ16]
                    page_valid_q <= '0;
                    page_dirty_q <= 1'b0;
                end
            end
            else if (stop_cond)
            begin
                ack_drive_q <= 1'b0;
                tx_bit_q <= 1'b1;
                ack_phase_q <= 1'b0;
                prog_cnt_q <= 32'h0;
                state_q <= page_dirty_q ? ST_PROGRAM : ST_IDLE;
            end
            else if (start_cond)
            begin
                state_q <= ST_DEVADDR;
                bit_q <= 4'h0;
                ack_phase_q <= 1'b0;
                ack_drive_q <= 1'b0;
                tx_bit_q <= 1'b1;
            end
            else if (state_q != ST_IDLE && state_q != ST_IGNORE)
            begin
                if (scl_rise && !ack_phase_q)
                begin
                    shift_q <= rx_byte; // [RQ1]
                    bit_q <= bit_q + 4'h1;
                end
                if (scl_rise && ack_phase_q && state_q == ST_RDATA)
                    nack_seen_q <= bus_in.sda;
                if (byte_done)
                begin
                    // While sending, the ninth clock opens at the release below
                    ack_phase_q <= (state_q != ST_RDATA);
                    case (state_q)
                        ST_DEVADDR:
                        begin
                            if (!addr_match)
                                state_q <= ST_IGNORE;
                        end
                        ST_ADDR_HI: hi_q <= rx_byte;
                        ST_ADDR_LO:
                        begin
                            addr_q <= ADDR_BITS'({hi_q, rx_byte});
                            page_base_q <= (ADDR_BITS-`PAGE_ADDR_BITS)'({hi_q, rx_byte} >> `PAGE_ADDR_BITS);
                        end
                        ST_WDATA:
                        begin
                            if (!guarded)
                            begin
                                page_valid_q[addr_q[`PAGE_ADDR_BITS-1:0]] <= 1'b1;
                                page_dirty_q <= 1'b1;
                            end
                            // Offset wraps inside the page
                            addr_q[`PAGE_ADDR_BITS-1:0] <= addr_q[`PAGE_ADDR_BITS-1:0] + 6'h1;
                        end
                        default: ;
                    endcase
                end
                // Acknowledge is driven from the falling edge that opens the ninth clock
                if (scl_fall && ack_phase_q && bit_q == `BIT_COUNT_ACK && state_q != ST_RDATA)
                    ack_drive_q <= 1'b1; // [RQ1] [RQ15]
                if (ack_end && ack_drive_q)
                begin
                    ack_drive_q <= 1'b0;
                    ack_phase_q <= 1'b0;
                    bit_q <= 4'h0;
                    // Direction bit still sits in bit 0 of the shift register
                    if (state_q == ST_DEVADDR)
                        state_q <= shift_q[0] ? ST_RDATA : ST_ADDR_HI; // [RQ14]
                    else if (state_q == ST_ADDR_HI)
                        state_q <= ST_ADDR_LO;
                    else if (state_q == ST_ADDR_LO)
                        state_q <= ST_WDATA;
                    if (state_q == ST_DEVADDR && shift_q[0])
                        tx_bit_q <= mem[addr_q][7]; // [RQ1] [RQ8]
                end
                else if (ack_end && state_q == ST_RDATA && ack_phase_q)
                begin
                    // Controller acknowledge low continues the read
                    ack_phase_q <= 1'b0;
                    bit_q <= 4'h0;
                    if (nack_seen_q)
                    begin
                        tx_bit_q <= 1'b1;
                        state_q <= ST_IGNORE;
                    end
                    else
                        tx_bit_q <= mem[addr_q][7]; // [RQ8]
                end
                else if (scl_fall && state_q == ST_RDATA && !ack_phase_q)
                begin
                    if (bit_q == `BIT_COUNT_LAST)
                    begin
                        tx_bit_q <= 1'b1; // Release for controller acknowledge
                        ack_phase_q <= 1'b1;
                        addr_q <= addr_q + ADDR_BITS'(1);
                    end
                    else
                        tx_bit_q <= mem[addr_q][3'(7 - bit_q)]; // [RQ1]
                end
            end
        end
    end

    // Open drain: only ever pull low
    assign sda_oe = ack_drive_q || !tx_bit_q; // [RQ4]
    assign sda_out = 1'b0; // [RQ4]
    assign programming = (state_q == ST_PROGRAM);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_stop_dirty;
        stop_cond && page_dirty_q && state_q != ST_PROGRAM;
    endsequence
    property p_open_drain;
        @(posedge clk) disable iff (rst) sda_oe |-> !sda_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high"); // [RQ4]
    property p_prog_start;
        @(posedge clk) disable iff (rst) s_stop_dirty |=> programming;
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("program cycle not started"); // [RQ10]
    property p_no_ack_busy;
        @(posedge clk) disable iff (rst) programming |-> !ack_drive_q;
    endproperty
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while programming"); // [RQ16]
    property p_prog_len;
        @(posedge clk) disable iff (rst) programming |-> prog_cnt_q < 32'(PROG_CYCLES);
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("program cycle too long"); // [RQ10]
    property p_oe_change_low;
        @(posedge clk) disable iff (rst) $rose(sda_oe) && !programming |-> !scl_q;
    endproperty
    a_oe_change_low: assert property (p_oe_change_low) else $error("sda changed with scl high"); // [RQ1]
    property p_mismatch;
        @(posedge clk) disable iff (rst) byte_done && state_q == ST_DEVADDR && !addr_match |=> state_q == ST_IGNORE;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("foreign address accepted"); // [RQ5]
    property p_guard;
        @(posedge clk) disable iff (rst) byte_done && state_q == ST_WDATA && guarded |-> !wdata_push;
    endproperty
    a_guard: assert property (p_guard) else $error("guarded byte buffered"); // [RQ6]
    property p_start;
        @(posedge clk) disable iff (rst) start_cond && !programming |=> state_q == ST_DEVADDR && bit_q == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start not taken"); // [RQ13]
    property p_fifo_room;
        @(posedge clk) disable iff (rst) wdata_push |-> fifo_in_ready;
    endproperty
    a_fifo_room: assert property (p_fifo_room) else $error("page fifo overflow"); // [RQ12]
endmodule : eeprom_target
`default_nettype wire

//--- logic/eeprom_target_map.svh
// Constants of the two-wire EEPROM target: codes, sizes and timing
`ifndef EEPROM_TARGET_MAP_SVH
`define EEPROM_TARGET_MAP_SVH
`define DEV_TYPE_CODE 4'ha
`define PAGE_BYTES 64
`define PAGE_ADDR_BITS 6
`define FIFO_DEPTH 4
`define CLK_PERIOD_PS 4000
`define PROG_TIME_FAST_MS 10
`define PROG_TIME_SLOW_MS 15
`define PS_PER_MS 1000000000
`define BIT_COUNT_LAST 4'h8
`define BIT_COUNT_ACK 4'h8
`endif

//--- logic/eeprom_target_pkg.sv
// Types shared by the two-wire EEPROM target
`default_nettype none
package eeprom_target_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVADDR = 3'b001,
        ST_ADDR_HI = 3'b011,
        ST_ADDR_LO = 3'b010,
        ST_WDATA = 3'b110,
        ST_RDATA = 3'b111,
        ST_PROGRAM = 3'b101,
        ST_IGNORE = 3'b100
    } bus_state_t;

    typedef struct packed {
        logic [5:0] offset;
        logic [7:0] data;
    } page_word_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;
endpackage : eeprom_target_pkg
`default_nettype wire

//--- logic/page_fifo.sv
// Small valid/ready FIFO carrying received page bytes toward the page buffer
`timescale 1ns/10ps
`default_nettype none
module page_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("page_fifo depth must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = in_valid && !full;
    wire pop = out_valid && out_ready;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else if (flush)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule : page_fifo
`default_nettype wire

//--- tb/bus_controller_model.sv
// Two-wire bus controller model: drives SCL, pulls SDA low or lets the pull-up raise it
`timescale 1ns/10ps
`default_nettype none
module bus_controller_model #(
    parameter int HALF = 313
) (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    localparam int Q = HALF / 2;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_c(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_c

    // One bit: data set in the low phase, line read at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low <= ~b;
        wait_c(Q);
        scl <= 1'b1;
        wait_c(HALF);
        r = sda_line;
        scl <= 1'b0;
        wait_c(HALF - Q);
    endtask : bit_io

    task automatic start_cond();
        sda_low <= 1'b0;
        wait_c(Q);
        scl <= 1'b1;
        wait_c(HALF);
        sda_low <= 1'b1;
        wait_c(HALF);
        scl <= 1'b0;
        wait_c(HALF - Q);
    endtask : start_cond

    // Clock stands high and SDA is released after the stop
    task automatic stop_cond();
        sda_low <= 1'b1;
        wait_c(Q);
        scl <= 1'b1;
        wait_c(HALF);
        sda_low <= 1'b0;
        wait_c(HALF);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] v, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, nack);
    endtask : send_byte

    task automatic recv_byte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, v[i]);
        bit_io(last, r);
    endtask : recv_byte
endmodule : bus_controller_model
`default_nettype wire

//--- tb/tb_eeprom_target.sv
// Self-checking bench of the two-wire EEPROM target
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_target_map.svh"
module tb_eeprom_target;
    import eeprom_target_pkg::*;
    localparam longint PROG = 7000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] bus_select_straps = 3'h0;
    logic write_guard = 1'b0;
    logic sda_out, sda_oe, programming, scl, sda_low, oe_q, scl_q;
    wire logic sda_line;
    bus_pins_t pins;
    int bad_count = 0;
    int n_tests = 0;
    longint t_end = 0;

    // Pull-up wins unless some party pulls low
    assign sda_line = !sda_low && !(sda_oe && !sda_out);
    assign pins = '{scl: scl, sda: sda_line};
    always #2 clk = ~clk;

    eeprom_target #(.ADDR_BITS(15), .PROG_CYCLES(PROG)) dut_u (
        .clk(clk), .rst(rst), .bus_in(pins), .sda_out(sda_out), .sda_oe(sda_oe),
        .bus_select_straps(bus_select_straps), .write_guard(write_guard), .programming(programming));
    bus_controller_model ctl_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    function automatic logic [7:0] dev(input logic [2:0] s, input logic rw);
        return {`DEV_TYPE_CODE, s, rw};
    endfunction : dev

    always @(negedge programming)
        t_end = $time;

    // Wire watch on settled values
    always @(negedge clk)
    begin
        oe_q <= sda_oe;
        scl_q <= scl;
        if (!rst && sda_oe === 1'b1)
            check(sda_out, 1'b0);
        if (!rst && scl && scl_q)
            check(sda_oe, oe_q);
    end

    task automatic wait_prog();
        int n;
        n = 0;
        while (programming !== 1'b0)
        begin
            @(posedge clk);
            n++;
            if (n > PROG + 50)
            begin
                bad_count++;
                conclude();
            end
        end
    endtask : wait_prog

    task automatic addr_phase(input logic [14:0] a);
        logic nk;
        ctl_u.start_cond();
        ctl_u.send_byte(dev(bus_select_straps, 1'b0), nk);
        check(nk, 1'b0);
        ctl_u.send_byte({1'b0, a[14:8]}, nk);
        check(nk, 1'b0);
        ctl_u.send_byte(a[7:0], nk);
        check(nk, 1'b0);
    endtask : addr_phase

    initial
    begin
        logic [14:0] t;
        logic [7:0] d0, d1, v;
        logic nk;
        int seed_v;
        longint t0;
        seed_v = $urandom(68334);
        // Even start offset keeps both bytes inside one page for the sequential read
        t = {3'b111, 11'($urandom), 1'b0};
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        @(posedge clk);
        bus_select_straps <= 3'($urandom);
        repeat (7) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        // Unguarded two-byte page write in the top eighth, then a poll
        addr_phase(t);
        ctl_u.send_byte(d0, nk);
        check(nk, 1'b0);
        ctl_u.send_byte(d1, nk);
        check(nk, 1'b0);
        ctl_u.stop_cond();
        t0 = $time;
        repeat (4) @(posedge clk);
        check(programming, 1'b1);
        ctl_u.start_cond();
        ctl_u.send_byte(dev(bus_select_straps, 1'b0), nk);
        check(nk, 1'b1);
        ctl_u.stop_cond();
        wait_prog();
        check((t_end - t0) / 4 <= PROG, 1'b1);
        check((t_end - t0) / 4 >= PROG - 400, 1'b1);
        // Guarded write is acknowledged but leaves the byte alone
        write_guard <= 1'b1;
        @(posedge clk);
        addr_phase(t);
        ctl_u.send_byte(~d0, nk);
        check(nk, 1'b0);
        ctl_u.stop_cond();
        repeat (4) @(posedge clk);
        wait_prog();
        // Random read with the guard still high
        addr_phase(t);
        ctl_u.start_cond();
        ctl_u.send_byte(dev(bus_select_straps, 1'b1), nk);
        check(nk, 1'b0);
        ctl_u.recv_byte(1'b0, v);
        check(v, d0);
        ctl_u.recv_byte(1'b1, v);
        check(v, d1);
        ctl_u.stop_cond();
        // Foreign strap code gets no acknowledge
        ctl_u.start_cond();
        ctl_u.send_byte(dev(bus_select_straps ^ 3'(1 + $urandom % 7), 1'b0), nk);
        check(nk, 1'b1);
        ctl_u.stop_cond();
        repeat (10) @(posedge clk);
        conclude();
    end
endmodule : tb_eeprom_target
`default_nettype wire
